// ==== spec_ctl_defines.vh ====
// Shared constants for the speculation checkpoint control block
`ifndef SPEC_CTL_DEFINES_VH
`define SPEC_CTL_DEFINES_VH
`define SPEC_MAX_LEVELS      3'd4
`define FPQ_DEPTH            3'd4
`define WBUF_DEPTH           3'd4
`define FP_DATA_W            64
`define ADDR_W               32
`define STATE_W              64
`define RECOVER_EARLY_CYC    3'd4
`define RECOVER_COMMIT_CYC   3'd5
`endif

// ==== checkpoint_store.v ====
// Four-slot checkpoint memory with registered read data
`timescale 1ns/1ps
module checkpoint_store #(
  parameter WIDTH = 64,
  parameter SLOTS = 4,
  parameter IDX_W = 2
) (
  // Clock
  input  wire             clk,
  // Write port
  input  wire             wr_en,
  input  wire [IDX_W-1:0] wr_idx,
  input  wire [WIDTH-1:0] wr_data,
  // Read port
  input  wire [IDX_W-1:0] rd_idx,
  output reg  [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:SLOTS-1];

  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule // checkpoint_store

// ==== speculation_checkpoint_control.v ====
// Speculation level, checkpoint, floating point queue and speculative write control
`timescale 1ns/1ps
`include "spec_ctl_defines.vh"
module speculation_checkpoint_control #(
  parameter STATE_W = `STATE_W,
  parameter ADDR_W  = `ADDR_W,
  parameter DATA_W  = `FP_DATA_W
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst,
  // Fetch and decode
  input  wire              pred_valid,
  input  wire [ADDR_W-1:0] pred_alt_addr,
  input  wire [STATE_W-1:0] machine_state,
  input  wire              dec_branch,
  input  wire              dec_fp,
  input  wire              fp_to_x_pipe,
  output wire              fp_pipe_sel_x,
  // Hazards
  input  wire              fault,
  input  wire              noncheckpoint_write,
  output wire              spec_stall,
  // Branch resolution
  input  wire              br_resolve,
  input  wire              br_mispredict,
  input  wire              br_flags_early,
  output reg               redirect_valid,
  output reg  [ADDR_W-1:0] redirect_addr,
  output reg               restore_valid,
  output wire [STATE_W-1:0] restore_state,
  output reg               recover_busy,
  // Second address stage dispatch
  input  wire              ac_fp_valid,
  input  wire              ac_mmu_exc,
  input  wire [DATA_W-1:0] ac_fp_operand,
  output reg               fpq_valid,
  output reg  [DATA_W-1:0] fpq_operand,
  input  wire              fpq_ready,
  output wire              fpq_full,
  input  wire              fp_done,
  output reg               exc_report,
  // Speculative writes
  input  wire              sw_valid,
  input  wire [ADDR_W-1:0] sw_addr,
  input  wire [DATA_W-1:0] sw_data,
  output wire              sw_ready,
  output reg               mem_wr_valid,
  output reg  [ADDR_W-1:0] mem_wr_addr,
  output reg  [DATA_W-1:0] mem_wr_data,
  input  wire              mem_wr_ready,
  // Status
  output wire [2:0]        spec_level
);
  // ==========================================
  // Speculation level and checkpoint ring
  // ==========================================
  reg  [2:0] level_q;
  reg  [1:0] ckpt_head_q;
  reg  [1:0] ckpt_tail_q;
  reg  [ADDR_W-1:0] alt_addr_q [0:3];
  reg  [2:0] fpq_cnt_q;
  reg  [2:0] fpq_unsent_q;
  reg  [1:0] fpq_wr_q;
  reg  [1:0] fpq_rd_q;
  reg  [DATA_W-1:0] fpq_mem_q [0:3];
  reg  [2:0] recov_cnt_q;
  reg  [2:0] wb_cnt_q;
  reg  [1:0] wb_head_q;
  reg  [1:0] wb_tail_q;
  reg  [2:0] wb_commit_q;
  reg  [ADDR_W-1:0] wb_addr_q [0:3];
  reg  [DATA_W-1:0] wb_data_q [0:3];

  // ==========================================
  // Stall conditions and pipe steering
  // ==========================================
  // Recovery keeps the front end stalled too
  wire level_full = (level_q == `SPEC_MAX_LEVELS);
  wire spec_open  = dec_branch | dec_fp;
  assign spec_stall = (spec_open & level_full)
                    | fault
                    | (wb_cnt_q == `WBUF_DEPTH)
                    | noncheckpoint_write
                    | recover_busy;
  assign fp_pipe_sel_x = dec_fp | fp_to_x_pipe;
  assign spec_level = level_q;

  wire fp_take  = ac_fp_valid & ~ac_mmu_exc & ~level_full
                & (fpq_cnt_q != `FPQ_DEPTH);
  wire br_take  = pred_valid & ~level_full & ~recover_busy;
  wire take     = br_take | fp_take;
  // Branch checkpoint wins over a float op in one cycle
  wire take_fp  = ~br_take & fp_take;
  wire ckpt_free = (br_resolve & ~br_mispredict) | fp_done;
  wire ckpt_pop  = ckpt_free & (level_q != 3'h0);
  wire mispred  = br_resolve & br_mispredict;
  assign fpq_full = (fpq_cnt_q == `FPQ_DEPTH);

  function [2:0] adj;
    input [2:0] v;
    input       up;
    input       dn;
    begin
      adj = v + {2'b00, up} - {2'b00, dn};
    end
  endfunction

  function [1:0] ptr_inc;
    input [1:0] p;
    begin
      ptr_inc = p + 2'h1;
    end
  endfunction

  // ==========================================
  // Checkpoint memory
  // ==========================================
  checkpoint_store #(
    .WIDTH (STATE_W),
    .SLOTS (4),
    .IDX_W (2)
  ) u_store (
    .clk     (clk),
    .wr_en   (take),
    .wr_idx  (ckpt_tail_q),
    .wr_data (machine_state),
    .rd_idx  (ckpt_head_q),
    .rd_data (restore_state)
  );

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      level_q      <= 3'h0;
      ckpt_head_q  <= 2'h0;
      ckpt_tail_q  <= 2'h0;
      alt_addr_q[0] <= {ADDR_W{1'b0}};
      alt_addr_q[1] <= {ADDR_W{1'b0}};
      alt_addr_q[2] <= {ADDR_W{1'b0}};
      alt_addr_q[3] <= {ADDR_W{1'b0}};
    end
    else if (mispred)
    begin
      // Everything younger than the mispredicted branch is discarded
      level_q     <= 3'h0;
      ckpt_tail_q <= ckpt_head_q;
    end
    else
    begin
      // Level never wraps below zero after a flush
      level_q <= adj(level_q, take, ckpt_pop);
      if (take)
      begin
        ckpt_tail_q <= ptr_inc(ckpt_tail_q);
        alt_addr_q[ckpt_tail_q] <= pred_alt_addr;
      end
      if (ckpt_pop)
      begin
        ckpt_head_q <= ptr_inc(ckpt_head_q);
      end
    end
  end

  // ==========================================
  // Misprediction recovery
  // ==========================================
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      redirect_valid <= 1'b0;
      redirect_addr  <= {ADDR_W{1'b0}};
      restore_valid  <= 1'b0;
      recover_busy   <= 1'b0;
      recov_cnt_q    <= 3'h0;
    end
    else
    begin
      redirect_valid <= mispred;
      restore_valid  <= mispred;
      if (mispred)
      begin
        redirect_addr <= alt_addr_q[ckpt_head_q];
        recover_busy  <= 1'b1;
        // Busy also spans the loading cycle, so load one less
        recov_cnt_q   <= br_flags_early ? `RECOVER_EARLY_CYC - 3'h1
                                        : `RECOVER_COMMIT_CYC - 3'h1;
      end
      else if (recov_cnt_q != 3'h0)
      begin
        recov_cnt_q <= recov_cnt_q - 3'h1;
      end
      else
      begin
        recover_busy <= 1'b0;
      end
    end
  end

  // ==========================================
  // Floating point queue dispatch
  // ==========================================
  wire fpq_pop  = fpq_valid & fpq_ready;
  wire fpq_load = (~fpq_valid | fpq_pop) & (fpq_unsent_q != 3'h0);

  // Operand slots need no reset; the counters guard them
  always @(posedge clk)
  begin
    if (take_fp)
    begin
      fpq_mem_q[fpq_wr_q] <= ac_fp_operand;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fpq_cnt_q    <= 3'h0;
      fpq_unsent_q <= 3'h0;
      fpq_wr_q     <= 2'h0;
      fpq_rd_q     <= 2'h0;
      fpq_valid    <= 1'b0;
      fpq_operand  <= {DATA_W{1'b0}};
      exc_report   <= 1'b0;
    end
    else
    begin
      // Exception only reported once older writes and float ops are gone
      exc_report   <= ac_fp_valid & ac_mmu_exc & (wb_cnt_q == 3'h0)
                    & (fpq_cnt_q == 3'h0);
      fpq_cnt_q    <= adj(fpq_cnt_q, take_fp, fp_done & (fpq_cnt_q != 3'h0));
      fpq_unsent_q <= adj(fpq_unsent_q, take_fp, fpq_load);
      if (take_fp)
      begin
        fpq_wr_q <= ptr_inc(fpq_wr_q);
      end
      if (fpq_load)
      begin
        // Oldest queued op is offered to the float unit first
        fpq_valid   <= 1'b1;
        fpq_operand <= fpq_mem_q[fpq_rd_q];
        fpq_rd_q    <= ptr_inc(fpq_rd_q);
      end
      else if (fpq_pop)
      begin
        fpq_valid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Speculative write buffers
  // ==========================================
  wire sw_push = sw_valid & sw_ready;
  wire sw_pop  = mem_wr_valid & mem_wr_ready;
  wire commit  = ckpt_free & (wb_commit_q != wb_cnt_q);
  assign sw_ready = (wb_cnt_q != `WBUF_DEPTH);

  // Buffer slots need no reset; the counters guard them
  always @(posedge clk)
  begin
    if (sw_push && !mispred)
    begin
      wb_addr_q[wb_tail_q] <= sw_addr;
      wb_data_q[wb_tail_q] <= sw_data;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_cnt_q     <= 3'h0;
      wb_commit_q  <= 3'h0;
      wb_head_q    <= 2'h0;
      wb_tail_q    <= 2'h0;
      mem_wr_valid <= 1'b0;
      mem_wr_addr  <= {ADDR_W{1'b0}};
      mem_wr_data  <= {DATA_W{1'b0}};
    end
    else if (mispred)
    begin
      // Uncommitted writes dropped; committed ones still drain
      wb_cnt_q    <= wb_commit_q - {2'b00, sw_pop};
      wb_tail_q   <= wb_head_q + wb_commit_q[1:0];
      wb_commit_q <= wb_commit_q - {2'b00, sw_pop};
      if (sw_pop)
      begin
        wb_head_q    <= ptr_inc(wb_head_q);
        mem_wr_valid <= 1'b0;
      end
    end
    else
    begin
      wb_cnt_q    <= adj(wb_cnt_q, sw_push, sw_pop);
      // Writes made with nothing unresolved are final at once
      wb_commit_q <= adj(wb_commit_q, commit | (level_q == 3'h0 && sw_push), sw_pop);
      if (sw_push)
      begin
        wb_tail_q <= ptr_inc(wb_tail_q);
      end
      if (sw_pop)
      begin
        wb_head_q    <= ptr_inc(wb_head_q);
        mem_wr_valid <= 1'b0;
      end
      else if (!mem_wr_valid && wb_commit_q != 3'h0)
      begin
        // Oldest resolved entry leaves first
        mem_wr_valid <= 1'b1;
        mem_wr_addr  <= wb_addr_q[wb_head_q];
        mem_wr_data  <= wb_data_q[wb_head_q];
      end
    end
  end
endmodule // speculation_checkpoint_control

// ==== fpu_model.sv ====
// Stand-in for the floating point unit and the memory write path
`timescale 1ns/1ps
module fpu_model (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Stall request from the bench
  input  wire hold,
  // Queue and write path
  input  wire fpq_valid,
  output wire fpq_ready,
  output reg  fp_done,
  input  wire mem_wr_valid,
  output wire mem_wr_ready
);
  reg [2:0] pend_q;
  // ==========
  // Accept and complete, one op a cycle
  assign fpq_ready    = !hold;
  assign mem_wr_ready = !hold;
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      pend_q  <= 3'h0;
      fp_done <= 1'b0;
    end
    else
    begin
      fp_done <= (pend_q != 3'h0) && !hold;
      pend_q  <= pend_q + {2'h0, fpq_valid && !hold} - {2'h0, (pend_q != 3'h0) && !hold};
    end
endmodule // fpu_model

// ==== spec_ctl_monitor.sv ====
// Port assertions for the speculation checkpoint control block
`timescale 1ns/1ps
module spec_ctl_monitor (
  // Clock and reset
  input wire       clk,
  input wire       rst,
  // Fetch, decode and hazards
  input wire       pred_valid,
  input wire       dec_branch,
  input wire       dec_fp,
  input wire       fp_to_x_pipe,
  input wire       fp_pipe_sel_x,
  input wire       fault,
  input wire       noncheckpoint_write,
  input wire       spec_stall,
  // Branch resolution
  input wire       br_resolve,
  input wire       br_mispredict,
  input wire       br_flags_early,
  input wire       redirect_valid,
  input wire       restore_valid,
  input wire       recover_busy,
  // Float dispatch, writes and status
  input wire       ac_fp_valid,
  input wire       fp_done,
  input wire       sw_ready,
  input wire [2:0] spec_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire mis   = br_resolve && br_mispredict && !recover_busy;
  wire quiet = !ac_fp_valid && !fp_done && !recover_busy && !spec_stall;
  // ==========
  // Recovery sequences
  sequence busy_early; recover_busy [*4] ##1 !recover_busy; endsequence
  sequence busy_late; recover_busy [*5] ##1 !recover_busy; endsequence
  chk_level_bound: assert property (spec_level <= 3'h4) else $error("level above four");
  chk_level_up: assert property (pred_valid && !br_resolve && quiet && spec_level < 3'h4
    |=> spec_level == $past(spec_level) + 3'h1) else $error("take did not raise level");
  chk_level_down: assert property (br_resolve && !br_mispredict && !pred_valid && quiet && spec_level != 3'h0
    |=> spec_level == $past(spec_level) - 3'h1) else $error("resolve did not lower level");
  chk_restore_next: assert property (mis |=> redirect_valid && restore_valid && spec_level == 3'h0)
    else $error("no restore after mispredict");
  chk_recover_early: assert property (mis && br_flags_early |=> busy_early) else $error("early recovery length");
  chk_recover_late: assert property (mis && !br_flags_early |=> busy_late) else $error("late recovery length");
  chk_stall_full: assert property (spec_level == 3'h4 && (dec_branch || dec_fp) |-> spec_stall)
    else $error("no stall at full level");
  chk_stall_fault: assert property (fault |-> spec_stall) else $error("no stall on fault");
  chk_stall_wbuf: assert property (!sw_ready |-> spec_stall) else $error("no stall on full buffers");
  chk_stall_nockpt: assert property (noncheckpoint_write |-> spec_stall) else $error("no stall on write");
  chk_x_pipe: assert property (fp_pipe_sel_x == (dec_fp || fp_to_x_pipe)) else $error("float op off X");
endmodule // spec_ctl_monitor
bind speculation_checkpoint_control spec_ctl_monitor mon (.clk, .rst, .pred_valid, .dec_branch, .dec_fp,
  .fp_to_x_pipe, .fp_pipe_sel_x, .fault, .noncheckpoint_write, .spec_stall, .br_resolve, .br_mispredict,
  .br_flags_early, .redirect_valid, .restore_valid, .recover_busy, .ac_fp_valid, .fp_done, .sw_ready, .spec_level);

// ==== speculation_checkpoint_control_tb.sv ====
// Self-checking bench for the speculation checkpoint control block
`timescale 1ns/1ps
`include "spec_ctl_defines.vh"
module speculation_checkpoint_control_tb;
  reg clk = 0, rst = 1, pred_valid = 0, dec_branch = 0, dec_fp = 0, fp_to_x_pipe = 0, fault = 0, hold = 1;
  reg noncheckpoint_write = 0, br_resolve = 0, br_mispredict = 0, br_flags_early = 0;
  reg ac_fp_valid = 0, ac_mmu_exc = 0, sw_valid = 0;
  reg [31:0] pred_alt_addr = 0, sw_addr = 0, seed = 32'h6dca6eb2, a, r, wa [0:3];
  reg [63:0] machine_state = 0, ac_fp_operand = 0, sw_data = 0, s, wd [0:3], op [0:3];
  wire fpq_ready, fp_done, mem_wr_ready, fp_pipe_sel_x, spec_stall, redirect_valid, restore_valid;
  wire recover_busy, fpq_valid, fpq_full, exc_report, sw_ready, mem_wr_valid;
  wire [31:0] redirect_addr, mem_wr_addr;
  wire [63:0] restore_state, fpq_operand, mem_wr_data;
  wire [2:0] spec_level;
  integer mismatches = 0, total_checks = 0, i, n;
  reg [63:0] st_q [$];
  reg [31:0] ad_q [$];
  speculation_checkpoint_control dut (.clk, .rst, .pred_valid, .pred_alt_addr, .machine_state, .dec_branch,
    .dec_fp, .fp_to_x_pipe, .fp_pipe_sel_x, .fault, .noncheckpoint_write, .spec_stall, .br_resolve,
    .br_mispredict, .br_flags_early, .redirect_valid, .redirect_addr, .restore_valid, .restore_state,
    .recover_busy, .ac_fp_valid, .ac_mmu_exc, .ac_fp_operand, .fpq_valid, .fpq_operand, .fpq_ready,
    .fpq_full, .fp_done, .exc_report, .sw_valid, .sw_addr, .sw_data, .sw_ready, .mem_wr_valid,
    .mem_wr_addr, .mem_wr_data, .mem_wr_ready, .spec_level);
  fpu_model partner (.clk, .rst, .hold, .fpq_valid, .fpq_ready, .fp_done, .mem_wr_valid, .mem_wr_ready);
  always #12.5 clk = ~clk;
  // ==========
  // Helpers
  function [2:0] exp_busy(input e);
    exp_busy = e ? `RECOVER_EARLY_CYC : `RECOVER_COMMIT_CYC;
  endfunction
  task chk(input [63:0] g, input [63:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task take(input integer k);
    integer j;
    begin
      for (j = 0; j < k; j = j + 1)
      begin
        s = {$random(seed), $random(seed)};
        a = $random(seed);
        @(posedge clk) begin pred_valid <= 1; machine_state <= s; pred_alt_addr <= a; end
        if (j < 4) begin st_q.push_back(s); ad_q.push_back(a); end
      end
      @(posedge clk) pred_valid <= 0;
    end
  endtask
  task mis(input e);
    begin
      @(posedge clk) begin br_resolve <= 1; br_mispredict <= 1; br_flags_early <= e; end
      @(posedge clk) begin br_resolve <= 0; br_mispredict <= 0; end
      @(negedge clk) chk(redirect_valid & restore_valid, 1);
      chk(restore_state, st_q[0]);
      chk(redirect_addr, ad_q[0]);
      chk(spec_level, 0);
      n = 0;
      while (recover_busy === 1'b1 && n < 9) begin @(negedge clk); n = n + 1; end
      chk(n, exp_busy(e));
      st_q.delete();
      ad_q.delete();
      $display("mispredict test done");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // ==========
  // Scenarios
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(negedge clk) chk(spec_level, 0);
    chk({mem_wr_valid, fpq_valid, redirect_valid}, 0);
    @(posedge clk) fault <= 1;
    @(negedge clk) chk(spec_stall, 1);
    @(posedge clk) begin fault <= 0; noncheckpoint_write <= 1; end
    @(negedge clk) chk(spec_stall, 1);
    @(posedge clk) noncheckpoint_write <= 0;
    $display("reset and hazard test done");
    take(5);
    @(posedge clk) dec_branch <= 1;
    @(negedge clk) chk(spec_level, 4);
    chk(spec_stall, 1);
    @(posedge clk) begin dec_branch <= 0; br_resolve <= 1; end
    @(posedge clk) br_resolve <= 0;
    st_q.pop_front();
    ad_q.pop_front();
    @(negedge clk) chk(spec_level, 3);
    chk(restore_valid, 0);
    $display("level and release test done");
    mis(0);
    take(1);
    mis(1);
    @(posedge clk) begin ac_fp_valid <= 1; ac_mmu_exc <= 1; end
    for (i = 0; i < 4; i = i + 1)
    begin
      op[i] = {$random(seed), $random(seed)};
      r = $random(seed);
      @(posedge clk) begin ac_mmu_exc <= 0; ac_fp_operand <= op[i]; dec_fp <= r[0]; fp_to_x_pipe <= r[1]; end
      if (i == 0) @(negedge clk) chk(exc_report, 1);
    end
    @(posedge clk) begin ac_fp_valid <= 0; dec_fp <= 0; fp_to_x_pipe <= 0; end
    @(negedge clk) chk(spec_level, 4);
    chk(fpq_full, 1);
    chk(fpq_valid, 1);
    chk(fpq_operand, op[0]);
    @(posedge clk) hold <= 0;
    @(negedge clk) chk(fpq_operand, op[0]);
    @(negedge clk) chk(fpq_operand, op[1]);
    n = 0;
    while (spec_level !== 3'h0 && n < 40) begin @(negedge clk); n = n + 1; end
    chk(spec_level, 0);
    $display("float queue test done");
    for (i = 0; i < 4; i = i + 1)
    begin
      wa[i] = $random(seed);
      wd[i] = {$random(seed), $random(seed)};
      take(1);
      @(posedge clk) begin sw_valid <= 1; sw_addr <= wa[i]; sw_data <= wd[i]; end
      @(posedge clk) sw_valid <= 0;
      @(negedge clk) chk(mem_wr_valid, 0);
    end
    chk(sw_ready, 0);
    chk(spec_stall, 1);
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge clk) br_resolve <= 1;
      @(posedge clk) br_resolve <= 0;
      n = 0;
      while (mem_wr_valid !== 1'b1 && n < 20) begin @(negedge clk); n = n + 1; end
      chk(mem_wr_addr, wa[i]);
      chk(mem_wr_data, wd[i]);
    end
    $display("write hold test done");
    report_and_stop;
  end
  initial begin
    #200000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
endmodule // speculation_checkpoint_control_tb
